/* include/phycfg_pkg.sv */
// Constants and shared types for the page-0 configuration bank
package phycfg_pkg;

  localparam int CLK_MHZ = 200;
  localparam int REG_AW  = 5;

  // Register offsets on the management port
  localparam logic [REG_AW-1:0] OFF_EVT_STAT  = 5'h14;
  localparam logic [REG_AW-1:0] OFF_NEG_CTRL  = 5'h19;
  localparam logic [REG_AW-1:0] OFF_SB_CFG    = 5'h1a;
  localparam logic [REG_AW-1:0] OFF_STA_LO_L  = 5'h1b;
  localparam logic [REG_AW-1:0] OFF_STA_LO_H  = 5'h1c;
  localparam logic [REG_AW-1:0] OFF_STA_HI    = 5'h1d;
  localparam logic [REG_AW-1:0] OFF_IND_CFG   = 5'h1e;

  // Negotiation control fields
  localparam int NEG_RESTART_BIT = 10;
  localparam int NEG_GIG_DIS_BIT = 6;
  localparam int NEG_LPLU_BIT    = 2;

  // Sideband link configuration fields
  localparam int SB_FREQ_HI_BIT = 12;
  localparam int SB_FRAG_BIT    = 11;
  localparam int SB_APM_BIT     = 10;
  localparam int SB_PEC_BIT     = 9;
  localparam int SB_FREQ_LO_BIT = 8;
  localparam int SB_VALID_BIT   = 7;
  localparam int SB_ADDR_MSB    = 6;
  localparam int SB_ADDR_W      = 7;

  // Indicator configuration fields
  localparam int IND_NUM       = 3;
  localparam int IND_FIELD_W   = 5;
  localparam int IND_FLASH_OFS = 4;
  localparam int IND_POL_OFS   = 3;
  localparam int IND_SRC_W     = 3;
  localparam int IND_RATE_BIT  = 15;

  // Reset values
  localparam logic [15:0] NEG_CTRL_RST = 16'h0000;
  localparam logic [15:0] SB_CFG_RST   = 16'h0200;
  localparam logic [15:0] SB_CFG_WMASK = 16'h1fff;
  localparam logic [15:0] IND_CFG_RST  = 16'h18f4;

  // Indicator source codes
  localparam logic [2:0] SRC_L10_1000  = 3'h0;
  localparam logic [2:0] SRC_L100_1000 = 3'h1;
  localparam logic [2:0] SRC_LINK      = 3'h2;
  localparam logic [2:0] SRC_ACT       = 3'h3;
  localparam logic [2:0] SRC_LINK_IDLE = 3'h4;
  localparam logic [2:0] SRC_L10       = 3'h5;
  localparam logic [2:0] SRC_L100      = 3'h6;
  localparam logic [2:0] SRC_L1000     = 3'h7;

  // Link speed codes
  localparam logic [1:0] SPD_10   = 2'h0;
  localparam logic [1:0] SPD_100  = 2'h1;
  localparam logic [1:0] SPD_1000 = 2'h2;

  // Sideband bus frequency codes and timing
  localparam logic [1:0] FREQ_100K  = 2'h0;
  localparam logic [1:0] FREQ_400K  = 2'h1;
  localparam logic [1:0] FREQ_1000K = 2'h2;
  localparam logic [1:0] FREQ_RSVD  = 2'h3;
  localparam int SB_KHZ_LO  = 100;
  localparam int SB_KHZ_MID = 400;
  localparam int SB_KHZ_HI  = 1000;
  localparam int HALF_W     = 11;
  localparam logic [HALF_W-1:0] SB_HALF_100K  = HALF_W'(CLK_MHZ * 1000 / (2 * SB_KHZ_LO));
  localparam logic [HALF_W-1:0] SB_HALF_400K  = HALF_W'(CLK_MHZ * 1000 / (2 * SB_KHZ_MID));
  localparam logic [HALF_W-1:0] SB_HALF_1000K = HALF_W'(CLK_MHZ * 1000 / (2 * SB_KHZ_HI));
  localparam logic [6:0] SB_FRAG_LARGE = 7'h40;
  localparam logic [6:0] SB_FRAG_SMALL = 7'h20;

  // Blink timing
  localparam int BLINK_SLOW_MS      = 200;
  localparam int BLINK_FAST_MS      = 83;
  localparam int BLINK_SLOW_CYC_DEF = BLINK_SLOW_MS * CLK_MHZ * 1000;
  localparam int BLINK_FAST_CYC_DEF = BLINK_FAST_MS * CLK_MHZ * 1000;
  localparam int BLINK_CW           = 26;

  // Activity stretch in link clocks
  localparam logic [3:0] ACT_HOLD = 4'hf;

  // Event status bits
  localparam int EVT_LINK_CHG = 0;
  localparam int EVT_HOST_RST = 1;
  localparam int EVT_W        = 2;

  typedef struct packed {
    logic       up;
    logic [1:0] speed;
    logic       act;
  } phycfg_link_stat_t;

  typedef struct packed {
    logic              wr;
    logic [REG_AW-1:0] addr;
    logic [15:0]       wdata;
  } phycfg_reg_req_t;

  typedef struct packed {
    logic        valid;
    logic [1:0]  idx;
    logic [15:0] data;
  } phycfg_nvm_word_t;

endpackage

/* core/phycfg_bank.sv */
// Page-0 configuration bank: negotiation, sideband, station address, indicators
// How it works
// - Restart bit pulses negotiation, then self-clears
// - Gigabit-disable bit blocks 1000 Mb/s
// - Gigabit-disable: zero at power-on, set on host-reset fall
// - Low-power bit prefers lowest common speed
// - Two frequency bits pick sideband bus rate
// - Fragment bit selects 64 or 32 bytes
// - Error-code byte enabled by bit 9
// - No sideband mastering while address invalid
// - Seven-bit address is sideband target
// - Sideband config reset only by power-on
// - Station address low from words 0,1
// - Station address high from word 2
// - Blink 200 ms or 83 ms halves
// - Flash bit makes indicator blink
// - Polarity bit: zero low, one high
// - Three-bit source select per indicator
// - Speed codes follow maintained link
// - Code 011: link with traffic
// - Code 100: link without traffic
// - Sticky per-cause status, software clears
`timescale 1ns/10ps
module phycfg_bank
  import phycfg_pkg::*;
#(
  parameter int unsigned BLINK_SLOW_CYC = BLINK_SLOW_CYC_DEF,
  parameter int unsigned BLINK_FAST_CYC = BLINK_FAST_CYC_DEF
) (
  input  wire logic                    mclk,
  input  wire logic                    sys_rst,
  input  wire logic                    link_clk,
  input  wire phycfg_reg_req_t         reg_req,
  output wire logic [15:0]             reg_rdata,
  input  wire logic                    host_fundamental_reset_n,
  input  wire phycfg_nvm_word_t        nvm_word,
  input  wire logic                    link_up,
  input  wire logic [1:0]              link_speed,
  input  wire logic                    link_activity,
  output wire logic                    aneg_restart,
  output wire logic                    gigabit_disable,
  output wire logic                    lplu_en,
  output wire logic                    sb_path_active,
  output wire logic [HALF_W-1:0]       sb_half_period,
  output wire logic [6:0]              sb_frag_bytes,
  output wire logic                    sb_pec_en,
  output wire logic                    sb_apm_wol_en,
  output wire logic                    sb_master_allowed,
  output wire logic [SB_ADDR_W-1:0]    sb_target_addr,
  output wire logic [47:0]             station_addr,
  output wire logic [IND_NUM-1:0]      ind_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // State types

  typedef struct packed {
    logic [15:0]          neg_ctrl;
    logic [15:0]          sb_cfg;
    logic [31:0]          sta_lo;
    logic [15:0]          sta_hi;
    logic [15:0]          ind_cfg;
    logic [EVT_W-1:0]     evt;
    logic [1:0]           hrst_sync;
    logic                 hrst_prev;
    logic                 sb_path;
    phycfg_link_stat_t    lst_s1;
    phycfg_link_stat_t    lst_s2;
    phycfg_link_stat_t    lst_s3;
    phycfg_link_stat_t    lst;
    logic                 lst_up_prev;
    logic                 aneg_tgl;
    logic [BLINK_CW-1:0]  blink_cnt;
    logic                 blink_ph;
    logic [IND_NUM-1:0]   ind;
    logic [15:0]          rdata;
    logic [HALF_W-1:0]    half_per;
    logic [6:0]           frag;
  } phycfg_core_st_t;

  typedef struct packed {
    logic [1:0]           rst_sync;
    logic [1:0]           tgl_sync;
    logic                 tgl_prev;
    logic                 restart;
    phycfg_link_stat_t    stat;
    logic [3:0]           act_cnt;
  } phycfg_link_st_t;

  phycfg_core_st_t q;
  phycfg_core_st_t next_q;
  phycfg_link_st_t lk_q;
  phycfg_link_st_t next_lk_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  function automatic logic [IND_FIELD_W-1:0] ind_field(input logic [15:0] cfg, input int idx);
    ind_field = cfg[idx*IND_FIELD_W +: IND_FIELD_W];
  endfunction

  function automatic logic src_hit(input logic [2:0] code, input phycfg_link_stat_t s);
    logic hit;
    hit = 1'b0;
    unique case (code)
      SRC_L10_1000:  hit = s.up && (s.speed == SPD_10 || s.speed == SPD_1000);
      SRC_L100_1000: hit = s.up && (s.speed == SPD_100 || s.speed == SPD_1000);
      SRC_LINK:      hit = s.up;
      SRC_ACT:       hit = s.up && s.act;
      SRC_LINK_IDLE: hit = s.up && !s.act;
      SRC_L10:       hit = s.up && (s.speed == SPD_10);
      SRC_L100:      hit = s.up && (s.speed == SPD_100);
      SRC_L1000:     hit = s.up && (s.speed == SPD_1000);
    endcase
    src_hit = hit;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Core domain

  always_comb begin
    logic [BLINK_CW-1:0]    limit;
    logic [IND_FIELD_W-1:0] fld;
    logic                   on;
    limit = '0;
    fld   = '0;
    on    = 1'b0;
    next_q = q;

    next_q.hrst_sync   = {q.hrst_sync[0], host_fundamental_reset_n};
    next_q.hrst_prev   = q.hrst_sync[1];
    next_q.sb_path     = ~q.hrst_sync[1];
    next_q.lst_s1      = lk_q.stat;
    next_q.lst_s2      = q.lst_s1;
    next_q.lst_s3      = q.lst_s2;
    // Status word taken only once two samples agree, so no torn speed code
    if (q.lst_s2 == q.lst_s3) begin
      next_q.lst = q.lst_s2;
    end
    next_q.lst_up_prev = q.lst.up;

    if (reg_req.wr) begin
      case (reg_req.addr)
        OFF_NEG_CTRL: begin
          next_q.neg_ctrl = reg_req.wdata;
          next_q.neg_ctrl[NEG_RESTART_BIT] = 1'b0;
          if (reg_req.wdata[NEG_RESTART_BIT]) begin
            next_q.aneg_tgl = ~q.aneg_tgl;
          end
        end
        OFF_SB_CFG:   next_q.sb_cfg = reg_req.wdata & SB_CFG_WMASK;
        OFF_STA_LO_L: next_q.sta_lo[15:0] = reg_req.wdata;
        OFF_STA_LO_H: next_q.sta_lo[31:16] = reg_req.wdata;
        OFF_STA_HI:   next_q.sta_hi = reg_req.wdata;
        OFF_IND_CFG:  next_q.ind_cfg = reg_req.wdata;
        OFF_EVT_STAT: next_q.evt = q.evt & ~reg_req.wdata[EVT_W-1:0];
        default: ;
      endcase
    end

    // Loads from nonvolatile words take priority over a same-cycle write
    if (nvm_word.valid) begin
      case (nvm_word.idx)
        2'h0:    next_q.sta_lo[15:0]  = nvm_word.data;
        2'h1:    next_q.sta_lo[31:16] = nvm_word.data;
        2'h2:    next_q.sta_hi        = nvm_word.data;
        default: ;
      endcase
    end

    // Event sets come after clears so a same-cycle event is kept
    if (q.hrst_prev && !q.hrst_sync[1]) begin
      next_q.neg_ctrl[NEG_GIG_DIS_BIT] = 1'b1;
      next_q.evt[EVT_HOST_RST] = 1'b1;
    end
    if (q.lst.up != q.lst_up_prev) begin
      next_q.evt[EVT_LINK_CHG] = 1'b1;
    end

    unique case ({q.sb_cfg[SB_FREQ_HI_BIT], q.sb_cfg[SB_FREQ_LO_BIT]})
      FREQ_100K:  next_q.half_per = SB_HALF_100K;
      FREQ_400K:  next_q.half_per = SB_HALF_400K;
      FREQ_1000K: next_q.half_per = SB_HALF_1000K;
      FREQ_RSVD:  next_q.half_per = q.half_per;
    endcase
    next_q.frag = q.sb_cfg[SB_FRAG_BIT] ? SB_FRAG_LARGE : SB_FRAG_SMALL;

    // Shared blink phase; >= copes with a rate change mid-count
    limit = q.ind_cfg[IND_RATE_BIT] ? BLINK_CW'(BLINK_FAST_CYC - 1)
                                    : BLINK_CW'(BLINK_SLOW_CYC - 1);
    if (q.blink_cnt >= limit) begin
      next_q.blink_cnt = '0;
      next_q.blink_ph  = ~q.blink_ph;
    end else begin
      next_q.blink_cnt = q.blink_cnt + 1'b1;
    end

    for (int i = 0; i < IND_NUM; i++) begin
      fld = ind_field(q.ind_cfg, i);
      on  = src_hit(fld[IND_SRC_W-1:0], q.lst)
            && (!fld[IND_FLASH_OFS] || q.blink_ph);
      next_q.ind[i] = fld[IND_POL_OFS] ? on : ~on;
    end

    case (reg_req.addr)
      OFF_NEG_CTRL: next_q.rdata = q.neg_ctrl;
      OFF_SB_CFG:   next_q.rdata = q.sb_cfg;
      OFF_STA_LO_L: next_q.rdata = q.sta_lo[15:0];
      OFF_STA_LO_H: next_q.rdata = q.sta_lo[31:16];
      OFF_STA_HI:   next_q.rdata = q.sta_hi;
      OFF_IND_CFG:  next_q.rdata = q.ind_cfg;
      OFF_EVT_STAT: next_q.rdata = 16'(q.evt);
      default:      next_q.rdata = '0;
    endcase

    // Power-on reset is the only reset of this bank
    if (sys_rst) begin
      next_q           = '0;
      next_q.neg_ctrl  = NEG_CTRL_RST;
      next_q.sb_cfg    = SB_CFG_RST;
      next_q.ind_cfg   = IND_CFG_RST;
      next_q.hrst_sync = 2'h3;
      next_q.hrst_prev = 1'b1;
      next_q.half_per  = SB_HALF_100K;
      next_q.frag      = SB_FRAG_SMALL;
      next_q.ind       = '1;
    end
  end

  always_ff @(posedge mclk) begin
    q <= next_q;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Link domain

  always_comb begin
    next_lk_q          = lk_q;
    next_lk_q.rst_sync = {lk_q.rst_sync[0], sys_rst};
    next_lk_q.tgl_sync = {lk_q.tgl_sync[0], q.aneg_tgl};
    next_lk_q.tgl_prev = lk_q.tgl_sync[1];
    next_lk_q.restart  = lk_q.tgl_sync[1] ^ lk_q.tgl_prev;
    next_lk_q.stat.up    = link_up;
    next_lk_q.stat.speed = link_speed;
    if (link_activity) begin
      next_lk_q.act_cnt = ACT_HOLD;
    end else if (lk_q.act_cnt != '0) begin
      next_lk_q.act_cnt = lk_q.act_cnt - 1'b1;
    end
    // Stretched so short bursts survive the crossing
    next_lk_q.stat.act = link_activity || (lk_q.act_cnt != '0);
    if (lk_q.rst_sync[1]) begin
      next_lk_q.tgl_sync = '0;
      next_lk_q.tgl_prev = 1'b0;
      next_lk_q.restart  = 1'b0;
      next_lk_q.stat     = '0;
      next_lk_q.act_cnt  = '0;
    end
  end

  always_ff @(posedge link_clk) begin
    lk_q <= next_lk_q;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign reg_rdata         = q.rdata;
  assign aneg_restart      = lk_q.restart;
  assign gigabit_disable   = q.neg_ctrl[NEG_GIG_DIS_BIT];
  assign lplu_en           = q.neg_ctrl[NEG_LPLU_BIT];
  assign sb_path_active    = q.sb_path;
  assign sb_half_period    = q.half_per;
  assign sb_frag_bytes     = q.frag;
  assign sb_pec_en         = q.sb_cfg[SB_PEC_BIT];
  assign sb_apm_wol_en     = q.sb_cfg[SB_APM_BIT];
  assign sb_master_allowed = q.sb_cfg[SB_VALID_BIT];
  assign sb_target_addr    = q.sb_cfg[SB_ADDR_MSB:0];
  assign station_addr      = {q.sta_hi, q.sta_lo};
  assign ind_out           = q.ind;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  logic wr_neg;
  logic wr_sb;
  assign wr_neg = reg_req.wr && reg_req.addr == OFF_NEG_CTRL;
  assign wr_sb  = reg_req.wr && reg_req.addr == OFF_SB_CFG;

  AST_RESTART_TOGGLE: assert property (
    wr_neg && reg_req.wdata[NEG_RESTART_BIT]
      |=> $changed(q.aneg_tgl) && !q.neg_ctrl[NEG_RESTART_BIT])
    else $error("restart write did not launch or did not self-clear");

  AST_RESTART_PULSE: assert property (
    @(posedge link_clk) disable iff (lk_q.rst_sync[1])
    $changed(lk_q.tgl_sync[1]) |=> lk_q.restart ##1 !lk_q.restart)
    else $error("restart pulse wrong in link domain");

  AST_GIG_WRITE: assert property (
    wr_neg && !(q.hrst_prev && !q.hrst_sync[1]) |=>
      gigabit_disable == $past(reg_req.wdata[NEG_GIG_DIS_BIT]))
    else $error("gigabit disable not taken from write");

  AST_GIG_HOST_FALL: assert property (
    $fell(host_fundamental_reset_n) ##1 !host_fundamental_reset_n
      |-> ##2 gigabit_disable && sb_path_active)
    else $error("host reset fall did not set gigabit disable");

  AST_POR_DEFAULTS: assert property (
    $fell(sys_rst) |-> sb_pec_en && !sb_master_allowed && sb_target_addr == 7'h00
                       && !gigabit_disable && sb_frag_bytes == SB_FRAG_SMALL)
    else $error("power-on defaults wrong");

  AST_SB_HOLD: assert property (
    !wr_sb |=> $stable(q.sb_cfg))
    else $error("sideband config changed without a write");

  AST_FREQ_MAP: assert property (
    {q.sb_cfg[SB_FREQ_HI_BIT], q.sb_cfg[SB_FREQ_LO_BIT]} == FREQ_400K
      |=> sb_half_period == SB_HALF_400K)
    else $error("400 kHz half period wrong");

  AST_FREQ_RSVD_HOLD: assert property (
    {q.sb_cfg[SB_FREQ_HI_BIT], q.sb_cfg[SB_FREQ_LO_BIT]} == FREQ_RSVD |=> $stable(sb_half_period))
    else $error("reserved frequency code changed the rate");

  AST_LINK_SETTLED: assert property (
    $changed(q.lst) |-> $past(q.lst_s2) == $past(q.lst_s3))
    else $error("link status taken before two samples agreed");

  AST_FRAG_MAP: assert property (
    wr_sb |=> ##1 sb_frag_bytes ==
      ($past(reg_req.wdata[SB_FRAG_BIT], 2) ? SB_FRAG_LARGE : SB_FRAG_SMALL))
    else $error("fragment size wrong");

  AST_TARGET_ADDR: assert property (
    wr_sb |=> sb_target_addr == $past(reg_req.wdata[SB_ADDR_MSB:0])
              && sb_master_allowed == $past(reg_req.wdata[SB_VALID_BIT]))
    else $error("sideband target or valid not stored");

  AST_STA_LOW: assert property (
    nvm_word.valid && nvm_word.idx == 2'h1 |=> station_addr[31:16] == $past(nvm_word.data))
    else $error("station address low word not loaded");

  AST_STA_HIGH: assert property (
    nvm_word.valid && nvm_word.idx == 2'h2 |=> station_addr[47:32] == $past(nvm_word.data))
    else $error("station address high word not loaded");

  AST_BLINK_WRAP: assert property (
    $changed(q.blink_ph) |-> q.blink_cnt == '0 && $past(q.blink_cnt) >= BLINK_CW'(BLINK_FAST_CYC - 1))
    else $error("blink phase toggled early");

  AST_IND_STEADY: assert property (
    !q.ind_cfg[IND_FLASH_OFS] && q.ind_cfg[IND_POL_OFS] && q.ind_cfg[2:0] == SRC_LINK
    && q.lst.up |=> ind_out[0])
    else $error("steady active-high indicator not on");

  AST_IND_IDLE: assert property (
    !q.ind_cfg[IND_POL_OFS] && q.ind_cfg[2:0] == SRC_LINK_IDLE && q.lst.act |=> ind_out[0])
    else $error("link-idle indicator lit during activity");

  AST_EVT_STICKY: assert property (
    q.evt[EVT_HOST_RST] && !(reg_req.wr && reg_req.addr == OFF_EVT_STAT
                             && reg_req.wdata[EVT_HOST_RST]) |=> q.evt[EVT_HOST_RST])
    else $error("event status bit lost without a clear");

  COV_RESTART: cover property (wr_neg && reg_req.wdata[NEG_RESTART_BIT]);
  COV_HOST_FALL: cover property ($rose(q.evt[EVT_HOST_RST]));
  COV_BLINK: cover property ($changed(q.blink_ph) && q.ind_cfg[IND_RATE_BIT]);
  COV_LINK_EVT: cover property ($rose(q.evt[EVT_LINK_CHG]));
  COV_FREQ_RSVD: cover property ({q.sb_cfg[SB_FREQ_HI_BIT], q.sb_cfg[SB_FREQ_LO_BIT]} == FREQ_RSVD);

endmodule

/* tb/phycfg_ctrl_model.sv */
// Controller-side model driving the management register port
`timescale 1ns/10ps
module phycfg_ctrl_model
  import phycfg_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic [15:0] reg_rdata,
  output phycfg_reg_req_t  reg_req
);
  initial reg_req = '0;

  task automatic wr(input logic [REG_AW-1:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_req <= '{wr: 1'b1, addr: a, wdata: d};
    @(posedge mclk);
    reg_req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [REG_AW-1:0] a, output logic [15:0] d);
    @(posedge mclk);
    reg_req.addr <= a;
    @(posedge mclk);
    #1 d = reg_rdata;
  endtask

  // Address update always carries the valid flag
  task automatic set_sb(input logic [1:0] f, input logic fr, input logic pec,
                        input logic [6:0] a);
    wr(OFF_SB_CFG, {3'h0, f[1], fr, 1'b0, pec, f[0], 1'b1, a});
  endtask

  task automatic clr_evt(input logic [15:0] m);
    wr(OFF_EVT_STAT, m);
  endtask
endmodule

/* tb/phy_page0_config_and_indicators_test.sv */
// Self-checking bench for the page-0 configuration bank
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks_done++; \
  if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module phy_page0_config_and_indicators_test
  import phycfg_pkg::*;
;
  localparam int SLOW = 20;
  localparam int FAST = 8;
  logic mclk = 0, lclk = 0, sys_rst = 1, host_n = 1;
  logic link_up = 0, link_act = 0;
  logic [1:0] link_spd = SPD_10;
  phycfg_reg_req_t req;
  phycfg_nvm_word_t nvm = '0;
  logic [15:0] rdata, d;
  logic aneg, gig, lplu, sbp, pec, apm, mal;
  logic [HALF_W-1:0] half;
  logic [6:0] frag, tgt;
  logic [47:0] sta;
  logic [2:0] ind_out;
  int n_mismatch = 0, checks_done = 0;

  always #2.5 mclk = ~mclk;
  always #6 lclk = ~lclk;

  phycfg_ctrl_model i_phycfg_ctrl_model (.mclk(mclk), .reg_rdata(rdata), .reg_req(req));

  phycfg_bank #(.BLINK_SLOW_CYC(SLOW), .BLINK_FAST_CYC(FAST)) i_phycfg_bank (
    .mclk(mclk), .sys_rst(sys_rst), .link_clk(lclk), .reg_req(req), .reg_rdata(rdata),
    .host_fundamental_reset_n(host_n), .nvm_word(nvm), .link_up(link_up),
    .link_speed(link_spd), .link_activity(link_act), .aneg_restart(aneg),
    .gigabit_disable(gig), .lplu_en(lplu), .sb_path_active(sbp), .sb_half_period(half),
    .sb_frag_bytes(frag), .sb_pec_en(pec), .sb_apm_wol_en(apm), .sb_master_allowed(mal),
    .sb_target_addr(tgt), .station_addr(sta), .ind_out(ind_out));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    if (n_mismatch == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) begin @(posedge mclk); #1; end
  endtask

  task automatic wait_ind(input logic [2:0] e);
    for (int i = 0; i < 60 && ind_out !== e; i++) tick(1);
    `CHK("ind_out", e, ind_out)
  endtask

  task automatic set_link(input logic u, input logic [1:0] s, input logic a);
    @(posedge lclk);
    link_up <= u;
    link_spd <= s;
    link_act <= a;
  endtask

  task automatic blink_len(input int n);
    logic v;
    int c;
    v = ind_out[0];
    for (c = 0; c < 100 && ind_out[0] === v; c++) tick(1);
    v = ind_out[0];
    for (c = 0; c < 100 && ind_out[0] === v; c++) tick(1);
    `CHK("blink_len", n, c)
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    i_phycfg_ctrl_model.rd(OFF_SB_CFG, d);
    `CHK("sb_cfg", 16'h0200, d)
    i_phycfg_ctrl_model.rd(OFF_IND_CFG, d);
    `CHK("ind_cfg", 16'h18f4, d)
    `CHK("gig", 1'b0, gig)
    `CHK("pec", 1'b1, pec)
    `CHK("half", 11'h3e8, half)
    `CHK("frag", 7'h20, frag)
    `CHK("mal", 1'b0, mal)
    `CHK("apm", 1'b0, apm)
  endtask

  task automatic t_neg;
    bit seen;
    seen = 0;
    i_phycfg_ctrl_model.wr(OFF_NEG_CTRL, 16'h0444);
    tick(2);
    `CHK("gig", 1'b1, gig)
    `CHK("lplu", 1'b1, lplu)
    for (int i = 0; i < 12; i++) begin @(posedge lclk); #1 seen |= (aneg === 1'b1); end
    `CHK("aneg", 1'b1, seen)
    i_phycfg_ctrl_model.rd(OFF_NEG_CTRL, d);
    `CHK("neg_rd", 16'h0044, d)
    i_phycfg_ctrl_model.wr(OFF_NEG_CTRL, 16'h0000);
  endtask

  task automatic t_host;
    i_phycfg_ctrl_model.set_sb(2'h1, 1'b1, 1'b0, 7'h5a);
    @(posedge mclk) host_n <= 1'b0;
    tick(4);
    `CHK("gig", 1'b1, gig)
    `CHK("sbp", 1'b1, sbp)
    i_phycfg_ctrl_model.rd(OFF_SB_CFG, d);
    `CHK("sb_cfg", 16'h09da, d)
    i_phycfg_ctrl_model.rd(OFF_EVT_STAT, d);
    `CHK("evt", 16'h0002, d & 16'h0002)
    i_phycfg_ctrl_model.clr_evt(16'h0002);
    i_phycfg_ctrl_model.rd(OFF_EVT_STAT, d);
    `CHK("evt", 16'h0000, d & 16'h0002)
    @(posedge mclk) host_n <= 1'b1;
  endtask

  task automatic t_sb;
    logic [10:0] hp [4] = '{11'h3e8, 11'h0fa, 11'h064, 11'h064};
    for (int k = 0; k < 4; k++) begin
      i_phycfg_ctrl_model.set_sb(k[1:0], k[0], ~k[0], 7'h11 + 7'(k));
      tick(3);
      `CHK("half", hp[k], half)
      `CHK("frag", k[0] ? 7'h40 : 7'h20, frag)
      `CHK("pec", ~k[0], pec)
      `CHK("tgt", 7'h11 + 7'(k), tgt)
      `CHK("mal", 1'b1, mal)
    end
    i_phycfg_ctrl_model.wr(OFF_SB_CFG, 16'h0433);
    tick(2);
    `CHK("mal", 1'b0, mal)
    `CHK("apm", 1'b1, apm)
  endtask

  task automatic t_nvm;
    logic [15:0] w [3] = '{16'h1234, 16'h5678, 16'h9abc};
    for (int k = 0; k < 3; k++) begin
      @(posedge mclk) nvm <= '{valid: 1'b1, idx: 2'(k), data: w[k]};
      @(posedge mclk) nvm.valid <= 1'b0;
    end
    tick(2);
    `CHK("sta_lo", 32'h56781234, sta[31:0])
    `CHK("sta_hi", 16'h9abc, sta[47:32])
    i_phycfg_ctrl_model.rd(OFF_STA_HI, d);
    `CHK("sta_hi_rd", 16'h9abc, d)
  endtask

  task automatic t_ind;
    logic [15:0] cf [2] = '{16'h202a, 16'h15c7};
    logic [2:0] ex [6] = '{3'h7, 3'h1, 3'h5, 3'h1, 3'h7, 3'h4};
    for (int c = 0; c < 2; c++) begin
      i_phycfg_ctrl_model.wr(OFF_IND_CFG, cf[c]);
      tick(2);
      for (int s = 0; s < 3; s++) begin
        set_link(1'b1, 2'(s), 1'b0);
        wait_ind(ex[c * 3 + s]);
      end
    end
    i_phycfg_ctrl_model.wr(OFF_IND_CFG, 16'h34cf);
    wait_ind(3'h3);
    i_phycfg_ctrl_model.wr(OFF_IND_CFG, 16'h2a74);
    wait_ind(3'h6);
    set_link(1'b1, SPD_1000, 1'b1);
    wait_ind(3'h5);
    set_link(1'b0, SPD_1000, 1'b1);
    wait_ind(3'h3);
  endtask

  task automatic t_blink;
    i_phycfg_ctrl_model.wr(OFF_IND_CFG, 16'h1c52);
    set_link(1'b0, SPD_10, 1'b0);
    tick(60);
    wait_ind(3'h7);
    tick(50);
    `CHK("ind_off", 3'h7, ind_out)
    set_link(1'b1, SPD_10, 1'b0);
    tick(10);
    blink_len(SLOW);
    i_phycfg_ctrl_model.wr(OFF_IND_CFG, 16'h9c52);
    tick(4);
    blink_len(FAST);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    t_reset();
    t_neg();
    t_host();
    t_sb();
    t_nvm();
    t_ind();
    t_blink();
    end_sim();
  end

  initial begin
    repeat (50000) @(posedge mclk);
    n_mismatch++;
    end_sim();
  end
endmodule
